/* shared/urg_pkg.sv */
// constants and carrier types for the uart register layer
// Contract
// - full flag while tx fifo at capacity
// - not-full flag, absent in half duplex
// - empty flag while tx fifo holds nothing
// - sticky done after last byte shifted out
// - half duplex direction bit: set transmits
// - break request drives break on line
// - mark bit: next character parity one
// - later characters parity zero until re-armed
// - two-bit parity select field in control
// - parity field loads init, software rewrites
// - three-bit receive addressing field in control
// - simple build has no control register
// - send when fifo holds data, flow permits
// - empty fifo means line stays idle
// - rx fifo readable whenever not empty
// - receive interrupt signals data available
// - sticky bits clear on status read
// - interrupt is or of masked status
package urg_pkg;
	localparam int ADDR_W = 3;
	localparam logic [ADDR_W-1:0] OFS_TX_STS = 3'h0;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 3'h1;
	localparam logic [ADDR_W-1:0] OFS_TXDATA = 3'h2;
	localparam logic [ADDR_W-1:0] OFS_RXDATA = 3'h3;
	localparam logic [ADDR_W-1:0] OFS_TX_MASK = 3'h4;
	localparam logic [ADDR_W-1:0] OFS_RX_STS = 3'h5;
	localparam logic [ADDR_W-1:0] OFS_RX_MASK = 3'h6;
	localparam int TXS_FULL = 0;
	localparam int TXS_NFULL = 1;
	localparam int TXS_EMPTY = 2;
	localparam int TXS_DONE = 3;
	localparam int RXS_NEMPTY = 0;
	localparam int RXS_OVR = 1;
	localparam int CTL_DIR = 0;
	localparam int CTL_BRK = 1;
	localparam int CTL_MARK = 2;
	localparam int CTL_PAR_LSB = 3;
	localparam int CTL_AM_LSB = 5;
	localparam logic [2:0] CTL_LOW_RST = 3'h0;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam int CLK_HZ = 40000000;
	localparam int BAUD_BPS = 115200;
	localparam int BIT_CYC = CLK_HZ / BAUD_BPS;
	localparam int BRK_BITS = 11;
	localparam int FIFO_DEPTH = 4;
	typedef enum logic [1:0] {
		PAR_NONE = 2'h0,
		PAR_EVEN = 2'h1,
		PAR_ODD = 2'h2,
		PAR_MS = 2'h3
	} urg_par_t;
	typedef enum logic [2:0] {
		AM_NONE = 3'h0,
		AM_SW_BYTE = 3'h1,
		AM_SW_BUF = 3'h2,
		AM_HW_BYTE = 3'h3,
		AM_HW_BUF = 3'h4
	} urg_am_t;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} urg_req_t;
endpackage

/* verilog/urg_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module urg_sync #(
	parameter int W = 2,
	parameter logic [W-1:0] RST = '1
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// pins and clean levels
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} urg_sync_st_t;
	urg_sync_st_t s_r;
	urg_sync_st_t s_nxt;

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.s1 = din;
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
		for (int i = 0; i < W; i++)
		begin
			if (s_r.s2[i] == s_r.s3[i])
				s_nxt.q[i] = s_r.s3[i];
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			s_r <= {RST, RST, RST, RST};
		else
			s_r <= s_nxt;
	end

	assign dout = s_r.q;
endmodule // urg_sync
`default_nettype wire

/* verilog/urg_fifo.sv */
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module urg_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// fill side
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} urg_fifo_st_t;
	urg_fifo_st_t s_r;
	urg_fifo_st_t s_nxt;
	logic push;
	logic pop;

	assign in_ready = (s_r.cnt != (AW+1)'(DEPTH));
	assign out_valid = (s_r.cnt != '0);
	assign out_data = s_r.mem[s_r.rp];
	assign push = in_valid && in_ready;
	assign pop = out_ready && out_valid;

	always_comb
	begin
		s_nxt = s_r;
		if (push)
		begin
			s_nxt.mem[s_r.wp] = in_data;
			s_nxt.wp = (s_r.wp == AW'(DEPTH-1)) ? '0 : s_r.wp + 1'b1;
		end
		if (pop)
			s_nxt.rp = (s_r.rp == AW'(DEPTH-1)) ? '0 : s_r.rp + 1'b1;
		if (push && !pop)
			s_nxt.cnt = s_r.cnt + 1'b1;
		else if (pop && !push)
			s_nxt.cnt = s_r.cnt - 1'b1;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end
endmodule // urg_fifo
`default_nettype wire

/* verilog/urg_regs.sv */
// uart register layer with transmitter, receiver and data fifos
`timescale 1ns/1ps
`default_nettype none
module urg_regs #(
	parameter bit SIMPLE = 1'b0,
	parameter bit HALF_DUPLEX = 1'b0,
	parameter int BIT_CYC = urg_pkg::BIT_CYC,
	parameter int FIFO_DEPTH = urg_pkg::FIFO_DEPTH,
	parameter urg_pkg::urg_par_t PAR_INIT = urg_pkg::PAR_NONE,
	parameter urg_pkg::urg_am_t AM_INIT = urg_pkg::AM_NONE
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// register port
	input wire urg_pkg::urg_req_t req,
	output logic [7:0] rdata,
	// serial line
	input wire logic rxd,
	input wire logic cts_n,
	output logic txd,
	output logic tx_en,
	// configuration for the rest of the uart
	output logic hd_tx_dir,
	output urg_pkg::urg_am_t rx_addr_mode,
	// interrupts
	output logic tx_irq,
	output logic rx_irq
);
	import urg_pkg::*;

	localparam int CW = $clog2(BIT_CYC + 1);
	localparam logic [CW-1:0] LAST = CW'(BIT_CYC - 1);
	localparam logic [CW-1:0] HALF = CW'(BIT_CYC / 2);
	localparam logic [3:0] BRK_LAST = 4'(BRK_BITS - 1);
	localparam logic [7:0] CTRL_INIT = {AM_INIT, PAR_INIT, CTL_LOW_RST};

	typedef enum logic [2:0] {
		T_IDLE,
		T_START,
		T_DATA,
		T_PAR,
		T_STOP,
		T_BRK
	} urg_tst_t;

	typedef enum logic [2:0] {
		R_IDLE,
		R_START,
		R_DATA,
		R_PAR,
		R_STOP
	} urg_rst_t;

	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] tx_mask;
		logic [7:0] rx_mask;
		logic tx_done;
		logic rx_ovr;
		logic mark_used;
		logic [7:0] rdata;
		logic txd;
		logic tx_en;
		logic tx_irq;
		logic rx_irq;
		logic [CW-1:0] div;
		urg_tst_t tst;
		logic [3:0] tbit;
		logic [7:0] tsh;
		logic tpar;
		urg_par_t tpt;
		urg_rst_t rst;
		logic [CW-1:0] rcnt;
		logic [2:0] rbit;
		logic [7:0] rsh;
	} urg_st_t;

	urg_st_t s_r;
	urg_st_t s_nxt;

	logic rx_s;
	logic cts_s;
	logic tick;
	logic tx_push;
	logic tx_pop;
	logic txf_ready;
	logic txf_valid;
	logic [7:0] txf_data;
	logic rx_push;
	logic rx_pop;
	logic rxf_ready;
	logic rxf_valid;
	logic [7:0] rxf_data;
	logic [7:0] tx_sts;
	logic [7:0] rx_sts;
	logic dir_tx_ok;
	logic dir_rx_ok;
	urg_par_t par_sel;
	logic ctl_brk;
	logic ctl_mark;

	urg_sync #(
		.W(2),
		.RST(2'h3)
	) u_sync (
		.clk(clk),
		.nrst(nrst),
		.din({rxd, cts_n}),
		.dout({rx_s, cts_s})
	);

	urg_fifo #(
		.W(8),
		.DEPTH(FIFO_DEPTH)
	) u_txf (
		.clk(clk),
		.nrst(nrst),
		.in_valid(tx_push),
		.in_data(req.wdata),
		.in_ready(txf_ready),
		.out_valid(txf_valid),
		.out_ready(tx_pop),
		.out_data(txf_data)
	);

	urg_fifo #(
		.W(8),
		.DEPTH(FIFO_DEPTH)
	) u_rxf (
		.clk(clk),
		.nrst(nrst),
		.in_valid(rx_push),
		.in_data(s_r.rsh),
		.in_ready(rxf_ready),
		.out_valid(rxf_valid),
		.out_ready(rx_pop),
		.out_data(rxf_data)
	);

	// control fields
	assign par_sel = urg_par_t'(s_r.ctrl[CTL_PAR_LSB +: 2]);
	assign ctl_brk = s_r.ctrl[CTL_BRK];
	assign ctl_mark = s_r.ctrl[CTL_MARK];
	assign dir_tx_ok = !HALF_DUPLEX || s_r.ctrl[CTL_DIR];
	assign dir_rx_ok = !HALF_DUPLEX || !s_r.ctrl[CTL_DIR];
	assign tick = (s_r.div == LAST);
	// dma or cpu pushes at the data address; a full fifo drops the byte
	assign tx_push = req.wr && (req.addr == OFS_TXDATA);
	assign rx_pop = req.rd && (req.addr == OFS_RXDATA);

	// live status words
	always_comb
	begin
		tx_sts = 8'h00;
		tx_sts[TXS_FULL] = !txf_ready;
		tx_sts[TXS_NFULL] = !HALF_DUPLEX && txf_ready;
		tx_sts[TXS_EMPTY] = !txf_valid;
		tx_sts[TXS_DONE] = s_r.tx_done;
		rx_sts = 8'h00;
		rx_sts[RXS_NEMPTY] = rxf_valid;
		rx_sts[RXS_OVR] = s_r.rx_ovr;
	end

	always_comb
	begin
		s_nxt = s_r;
		tx_pop = 1'b0;
		rx_push = 1'b0;
		s_nxt.rdata = 8'h00;
		s_nxt.div = tick ? '0 : s_r.div + 1'b1;

		// register writes
		if (req.wr)
		begin
			case (req.addr)
				OFS_CTRL:
				begin
					if (!SIMPLE)
					begin
						s_nxt.ctrl = req.wdata;
						if (!req.wdata[CTL_MARK])
							s_nxt.mark_used = 1'b0;
					end
				end
				OFS_TX_MASK: s_nxt.tx_mask = req.wdata;
				OFS_RX_MASK: s_nxt.rx_mask = req.wdata;
				default: s_nxt.tx_mask = s_r.tx_mask;
			endcase
		end

		// register reads, answer in the next cycle
		if (req.rd)
		begin
			case (req.addr)
				OFS_TX_STS:
				begin
					s_nxt.rdata = tx_sts;
					s_nxt.tx_done = 1'b0;
				end
				OFS_CTRL: s_nxt.rdata = SIMPLE ? 8'h00 : s_r.ctrl;
				OFS_RXDATA: s_nxt.rdata = rxf_valid ? rxf_data : 8'h00;
				OFS_TX_MASK: s_nxt.rdata = s_r.tx_mask;
				OFS_RX_STS:
				begin
					s_nxt.rdata = rx_sts;
					s_nxt.rx_ovr = 1'b0;
				end
				OFS_RX_MASK: s_nxt.rdata = s_r.rx_mask;
				default: s_nxt.rdata = 8'h00;
			endcase
		end

		// transmitter, one step per bit tick
		if (tick)
		begin
			unique case (s_r.tst)
				T_IDLE:
				begin
					if (ctl_brk)
					begin
						s_nxt.tst = T_BRK;
						s_nxt.tbit = 4'h0;
						s_nxt.txd = 1'b0;
					end
					else if (txf_valid && !cts_s && dir_tx_ok)
					begin
						tx_pop = 1'b1;
						s_nxt.tsh = txf_data;
						s_nxt.tpt = par_sel;
						s_nxt.txd = 1'b0;
						s_nxt.tst = T_START;
						unique case (par_sel)
							PAR_EVEN: s_nxt.tpar = ^txf_data;
							PAR_ODD: s_nxt.tpar = ~^txf_data;
							PAR_MS:
							begin
								s_nxt.tpar = ctl_mark && !s_r.mark_used;
								if (ctl_mark)
									s_nxt.mark_used = 1'b1;
							end
							PAR_NONE: s_nxt.tpar = 1'b0;
						endcase
					end
				end
				T_START:
				begin
					s_nxt.tst = T_DATA;
					s_nxt.txd = s_r.tsh[0];
					s_nxt.tbit = 4'h0;
				end
				T_DATA:
				begin
					if (s_r.tbit == 4'h7)
					begin
						if (s_r.tpt == PAR_NONE)
						begin
							s_nxt.tst = T_STOP;
							s_nxt.txd = 1'b1;
						end
						else
						begin
							s_nxt.tst = T_PAR;
							s_nxt.txd = s_r.tpar;
						end
					end
					else
					begin
						s_nxt.tbit = s_r.tbit + 1'b1;
						s_nxt.tsh = s_r.tsh >> 1;
						s_nxt.txd = s_r.tsh[1];
					end
				end
				T_PAR:
				begin
					s_nxt.tst = T_STOP;
					s_nxt.txd = 1'b1;
				end
				T_STOP:
				begin
					s_nxt.tst = T_IDLE;
					s_nxt.txd = 1'b1;
					if (!txf_valid)
						s_nxt.tx_done = 1'b1;
				end
				T_BRK:
				begin
					s_nxt.txd = 1'b0;
					if (s_r.tbit != BRK_LAST)
						s_nxt.tbit = s_r.tbit + 1'b1;
					else if (!ctl_brk)
					begin
						s_nxt.tst = T_IDLE;
						s_nxt.txd = 1'b1;
					end
				end
			endcase
		end
		s_nxt.tx_en = (s_nxt.tst != T_IDLE);

		// receiver, samples at mid bit
		s_nxt.rcnt = s_r.rcnt + 1'b1;
		unique case (s_r.rst)
			R_IDLE:
			begin
				s_nxt.rcnt = '0;
				if (!rx_s && dir_rx_ok)
					s_nxt.rst = R_START;
			end
			R_START:
			begin
				if (s_r.rcnt == HALF)
				begin
					s_nxt.rcnt = '0;
					s_nxt.rbit = 3'h0;
					s_nxt.rst = rx_s ? R_IDLE : R_DATA;
				end
			end
			R_DATA:
			begin
				if (s_r.rcnt == LAST)
				begin
					s_nxt.rcnt = '0;
					s_nxt.rsh = {rx_s, s_r.rsh[7:1]};
					s_nxt.rbit = s_r.rbit + 1'b1;
					if (s_r.rbit == 3'h7)
						s_nxt.rst = (par_sel == PAR_NONE) ? R_STOP : R_PAR;
				end
			end
			R_PAR:
			begin
				if (s_r.rcnt == LAST)
				begin
					s_nxt.rcnt = '0;
					s_nxt.rst = R_STOP;
				end
			end
			R_STOP:
			begin
				if (s_r.rcnt == LAST)
				begin
					s_nxt.rst = R_IDLE;
					if (rx_s)
					begin
						rx_push = 1'b1;
						if (!rxf_ready)
							s_nxt.rx_ovr = 1'b1;
					end
				end
			end
		endcase

		// masked status onto the interrupt lines
		s_nxt.tx_irq = |(tx_sts & s_r.tx_mask);
		s_nxt.rx_irq = |(rx_sts & s_r.rx_mask);
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s_r <= '0;
			s_r.ctrl <= CTRL_INIT;
			s_r.tx_mask <= MASK_RST;
			s_r.rx_mask <= MASK_RST;
			s_r.txd <= 1'b1;
			s_r.tst <= T_IDLE;
			s_r.tpt <= PAR_NONE;
			s_r.rst <= R_IDLE;
		end
		else
			s_r <= s_nxt;
	end

	assign rdata = s_r.rdata;
	assign txd = s_r.txd;
	assign tx_en = s_r.tx_en;
	assign tx_irq = s_r.tx_irq;
	assign rx_irq = s_r.rx_irq;
	assign hd_tx_dir = s_r.ctrl[CTL_DIR];
	assign rx_addr_mode = urg_am_t'(s_r.ctrl[CTL_AM_LSB +: 3]);
endmodule // urg_regs
`default_nettype wire

/* sim/urg_regs_sva.sv */
// port assertions for the uart register layer
`timescale 1ns/1ps
`default_nettype none
module urg_regs_chk #(
	parameter int BIT_CYC = 8,
	parameter bit SIMPLE = 1'b0,
	parameter bit HALF_DUPLEX = 1'b0
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// register port
	input wire urg_pkg::urg_req_t req,
	input wire logic [7:0] rdata,
	// serial line
	input wire logic rxd,
	input wire logic cts_n,
	input wire logic txd,
	input wire logic tx_en,
	// configuration and interrupts
	input wire logic hd_tx_dir,
	input wire urg_pkg::urg_am_t rx_addr_mode,
	input wire logic tx_irq,
	input wire logic rx_irq
);
	import urg_pkg::*;
	int low_r;
	logic cw;
	// a simple build ignores control writes, so its config must hold still
	assign cw = req.wr && req.addr == OFS_CTRL && !SIMPLE;
	// length of the current low run on the line
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
			low_r <= 0;
		else
			low_r <= txd ? 0 : low_r + 1;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	property p_rd_quiet;
		!$past(req.rd) |-> rdata == 8'h00;
	endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("rdata not zero");
	property p_dir;
		cw |=> hd_tx_dir == $past(req.wdata[0]);
	endproperty
	a_dir: assert property (p_dir) else $error("direction bit wrong");
	property p_am;
		cw |=> rx_addr_mode == $past(req.wdata[7:5]);
	endproperty
	a_am: assert property (p_am) else $error("addressing field wrong");
	property p_cfg_hold;
		!cw |=> $stable(rx_addr_mode) && $stable(hd_tx_dir);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("config moved");
	property p_idle_high;
		!tx_en |-> txd;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("idle line low");
	property p_start_en;
		$fell(txd) |-> tx_en;
	endproperty
	a_start_en: assert property (p_start_en) else $error("low without tx_en");
	property p_brk_len;
		$rose(txd) && low_r > 10 * BIT_CYC |-> low_r >= 11 * BIT_CYC - 1;
	endproperty
	a_brk_len: assert property (p_brk_len) else $error("break too short");
	property p_sts;
		req.rd && req.addr == OFS_TX_STS |=>
			rdata[1] == (!HALF_DUPLEX && !rdata[0]) && !(rdata[0] && rdata[2]);
	endproperty
	a_sts: assert property (p_sts) else $error("status flags clash");
	property p_rx_mask;
		req.wr && req.addr == OFS_RX_MASK && req.wdata == 8'h00 |=> ##1 !rx_irq;
	endproperty
	a_rx_mask: assert property (p_rx_mask) else $error("rx_irq unmasked");
	property p_tx_mask;
		req.wr && req.addr == OFS_TX_MASK && req.wdata == 8'h00 |=> ##1 !tx_irq;
	endproperty
	a_tx_mask: assert property (p_tx_mask) else $error("tx_irq unmasked");
	c_brk: cover property ($rose(txd) && low_r > 10 * BIT_CYC);
	c_rx: cover property (req.rd && req.addr == OFS_RXDATA ##1 rdata != 8'h00);
	c_full: cover property (req.rd && req.addr == OFS_TX_STS ##1 rdata[0]);
endmodule // urg_regs_chk
`default_nettype wire

/* sim/urg_peer.sv */
// remote serial node: sends on rxd, decodes frames from txd
`timescale 1ns/1ps
`default_nettype none
module urg_peer #(
	parameter int BIT_CYC = 8
) (
	// clock
	input wire logic clk,
	// line from the block and parity setting
	input wire logic txd,
	input wire logic par_en,
	// line to the block
	output logic rxd
);
	logic [8:0] got_q[$];
	logic [8:0] sh;
	initial rxd = 1'b1;
	// one frame, line idles high after the stop bit
	task automatic send(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			@(posedge clk);
			rxd <= f[i];
			repeat (BIT_CYC - 1) @(posedge clk);
		end
	endtask
	// decoder, parity kept in bit 8, framing errors dropped
	always
	begin
		@(negedge txd);
		repeat (BIT_CYC / 2) @(posedge clk);
		sh = 9'h000;
		for (int i = 0; i < 9; i++)
			if (i < 8 || par_en)
			begin
				repeat (BIT_CYC) @(posedge clk);
				sh[i] = txd;
			end
		repeat (BIT_CYC) @(posedge clk);
		if (txd)
			got_q.push_back(sh);
	end
endmodule // urg_peer
`default_nettype wire

/* sim/urg_regs_tb_top.sv */
// self-checking bench for the uart register layer
`timescale 1ns/1ps
`default_nettype none
module urg_regs_tb_top;
	import urg_pkg::*;
	localparam int BC = 8;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic cts_n = 1'b1;
	logic par_en = 1'b0;
	urg_req_t req = '0;
	logic [7:0] rdata;
	logic rxd, txd, tx_en, hd_tx_dir, tx_irq, rx_irq;
	logic [7:0] rdata_hd;
	logic [7:0] rdata_sp;
	logic tx_en_hd;
	urg_am_t rx_addr_mode;
	int failures = 0;
	int checks_done = 0;
	int cyc = 0;
	always #12.5 clk = ~clk;
	urg_regs #(.BIT_CYC(BC)) dut (.clk(clk), .nrst(nrst), .req(req), .rdata(rdata),
		.rxd(rxd), .cts_n(cts_n), .txd(txd), .tx_en(tx_en), .hd_tx_dir(hd_tx_dir),
		.rx_addr_mode(rx_addr_mode), .tx_irq(tx_irq), .rx_irq(rx_irq));
	urg_peer #(.BIT_CYC(BC)) peer (.clk(clk), .txd(txd), .par_en(par_en), .rxd(rxd));
	// half duplex and simple builds share the bus and see every access
	urg_regs #(.BIT_CYC(BC), .HALF_DUPLEX(1'b1)) dut_hd (.clk(clk), .nrst(nrst), .req(req),
		.rdata(rdata_hd), .rxd(rxd), .cts_n(cts_n), .txd(), .tx_en(tx_en_hd), .hd_tx_dir(),
		.rx_addr_mode(), .tx_irq(), .rx_irq());
	urg_regs #(.BIT_CYC(BC), .SIMPLE(1'b1)) dut_sp (.clk(clk), .nrst(nrst), .req(req),
		.rdata(rdata_sp), .rxd(rxd), .cts_n(cts_n), .txd(), .tx_en(), .hd_tx_dir(),
		.rx_addr_mode(), .tx_irq(), .rx_irq());
	task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
		checks_done++;
		if (g !== e)
		begin
			failures++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
		#1 chk($sformatf("rdata %0d", a), {1'b0, e}, {1'b0, rdata});
	endtask
	task automatic wait_rx(input int n);
		for (int i = 0; i < 4000 && peer.got_q.size() < n; i++)
			@(posedge clk);
		repeat (2 * BC) @(posedge clk);
	endtask
	task automatic results();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 10000)
		begin
			failures++;
			results();
		end
	end
	initial
	begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		rd(OFS_TX_STS, 8'h06);
		chk("hd status", 9'h004, {1'b0, rdata_hd});
		rd(OFS_CTRL, 8'h00);
		for (int m = 0; m < 5; m++)
		begin
			wr(OFS_CTRL, {m[2:0], m[1:0], 3'h1});
			rd(OFS_CTRL, {m[2:0], m[1:0], 3'h1});
			chk("simple ctrl", 9'h000, {1'b0, rdata_sp});
			chk("rx_addr_mode", {6'h0, m[2:0]}, {6'h0, rx_addr_mode});
			chk("hd_tx_dir", 9'h001, {8'h0, hd_tx_dir});
		end
		wr(OFS_CTRL, 8'h00);
		$display("test config done");
		for (int i = 1; i < 6; i++)
			wr(OFS_TXDATA, 8'(i * 17));
		rd(OFS_TX_STS, 8'h01);
		@(posedge clk);
		cts_n <= 1'b0;
		wait_rx(4);
		rd(OFS_TX_STS, 8'h0e);
		chk("hd held", 9'h001, {1'b0, rdata_hd});
		rd(OFS_TX_STS, 8'h06);
		repeat (20 * BC) @(posedge clk);
		chk("sent count", 9'h004, 9'(peer.got_q.size()));
		for (int i = 1; i < 5; i++)
			chk("sent byte", 9'(i * 17), peer.got_q[i - 1]);
		peer.got_q.delete();
		$display("test tx fifo done");
		par_en <= 1'b1;
		wr(OFS_CTRL, 8'h1c);
		wr(OFS_TXDATA, 8'h01);
		wr(OFS_TXDATA, 8'h01);
		wait_rx(2);
		wr(OFS_CTRL, 8'h08);
		wr(OFS_TXDATA, 8'h07);
		wait_rx(3);
		wr(OFS_CTRL, 8'h10);
		wr(OFS_TXDATA, 8'h07);
		wait_rx(4);
		chk("mark parity", 9'h101, peer.got_q[0]);
		chk("space parity", 9'h001, peer.got_q[1]);
		chk("even parity", 9'h107, peer.got_q[2]);
		chk("odd parity", 9'h007, peer.got_q[3]);
		par_en <= 1'b0;
		wr(OFS_CTRL, 8'h02);
		repeat (14 * BC) @(posedge clk);
		#1 chk("break line", 9'h000, {8'h0, txd});
		wr(OFS_CTRL, 8'h00);
		repeat (3 * BC) @(posedge clk);
		#1 chk("line after break", 9'h001, {8'h0, txd});
		$display("test parity break done");
		peer.send(8'ha5);
		repeat (2 * BC) @(posedge clk);
		rd(OFS_RX_STS, 8'h01);
		wr(OFS_RX_MASK, 8'h01);
		repeat (2) @(posedge clk);
		#1 chk("rx_irq", 9'h001, {8'h0, rx_irq});
		rd(OFS_RXDATA, 8'ha5);
		rd(OFS_RXDATA, 8'h00);
		chk("rx_irq drained", 9'h000, {8'h0, rx_irq});
		wr(OFS_RX_MASK, 8'h00);
		wr(OFS_TX_MASK, 8'h04);
		repeat (2) @(posedge clk);
		#1 chk("tx_irq", 9'h001, {8'h0, tx_irq});
		wr(OFS_TX_MASK, 8'h00);
		rd(3'h7, 8'h00);
		wr(OFS_CTRL, 8'h01);
		repeat (3 * BC) @(posedge clk);
		#1 chk("hd sending", 9'h001, {8'h0, tx_en_hd});
		peer.send(8'h3c);
		repeat (2 * BC) @(posedge clk);
		rd(OFS_RX_STS, 8'h01);
		chk("hd rx ignored", 9'h000, {1'b0, rdata_hd});
		$display("test rx irq done");
		results();
	end
endmodule // urg_regs_tb_top
bind urg_regs urg_regs_chk #(.BIT_CYC(BIT_CYC), .SIMPLE(SIMPLE), .HALF_DUPLEX(HALF_DUPLEX))
	chk_i (.clk(clk), .nrst(nrst), .req(req),
	.rdata(rdata), .rxd(rxd), .cts_n(cts_n), .txd(txd), .tx_en(tx_en), .hd_tx_dir(hd_tx_dir),
	.rx_addr_mode(rx_addr_mode), .tx_irq(tx_irq), .rx_irq(rx_irq));
`default_nettype wire
